// ==== rtl/pswg_gate_delay.sv ====
// One-instruction-cycle delay stage for module disable bits
`timescale 1ns/1ps
module pswg_gate_delay #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 1
)(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage_reg [DEPTH];

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				stage_reg[i] <= '0;
		end
		else
		begin
			stage_reg[0] <= din;
			for (int i = 1; i < DEPTH; i++)
				stage_reg[i] <= stage_reg[i-1];
		end
	end

	assign dout = stage_reg[DEPTH-1];

endmodule

// ==== rtl/pswg_pkg.sv ====
// Package of constants and types for the power-save wake and module gating block
// Notes on behaviour
// - Sleep wakes on enabled interrupt beating priority; vector to handler; set sleep flag. Code traps instead of vectoring only if oscillator not stable.
// - Oscillator dead after wake with fail-safe monitor on: clock trap, switch to RC.
// - Oscillator dead with fail-safe monitor off: stall and stay asleep until stable.
// - Any reset wakes from Sleep; power-on clears sleep flag, others set it.
// - Watchdog time-out in Sleep wakes and sets sleep and watchdog flags.
// - Idle stops only the CPU clock; peripherals and clock source keep running.
// - Peripheral idle-control bit decides whether it runs during Idle.
// - Low-power RC clock stays on in Idle while clock failure detection enabled.
// - Idle exits on qualified interrupt, any reset, or watchdog time-out.
// - Leaving Idle reapplies CPU clock at once, resumes after power-save instruction.
// - Leaving Idle uses no start-up or power-up delay.
// - Interrupt wake from Idle vectors to handler and sets idle flag.
// - Power-on reset clears idle flag; every other reset sets it.
// - Watchdog time-out in Idle wakes and sets idle and watchdog flags.
// - Configuration words are 24 bits; only low 16 bits hold data.
// - Software reads configuration words through table reads.
// - Set disable bit stops peripheral clocks; its registers ignore writes, read invalid.
// - Peripheral runs only if disable clear and present; present ones reset enabled.
// - Disable bit change takes effect one instruction cycle after the write.
// - Codec disable bit stays read/write on variants without codec, reads one when set.
// - With debugging on, first 80 RAM bytes and two pins go to the debugger.
// - Sleep stops CPU and peripheral clocks and oscillator; RC stays if watchdog runs.
package pswg_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [23:0] ADDR_RESET_POWER_STATUS = 24'h000740;
	localparam logic [23:0] ADDR_OSC_CONTROL = 24'h000742;
	localparam logic [23:0] ADDR_MODULE_DISABLE_ONE = 24'h000770;
	localparam logic [23:0] ADDR_MODULE_DISABLE_TWO = 24'h000772;
	localparam logic [23:0] ADDR_OSC_CONFIG = 24'hf80000;
	localparam logic [23:0] ADDR_WDT_CONFIG = 24'hf80002;
	localparam logic [23:0] ADDR_BOR_POR_CONFIG = 24'hf80004;
	localparam logic [23:0] ADDR_CODE_SEG_CONFIG = 24'hf8000a;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int BIT_POR = 0;
	localparam int BIT_BOR = 1;
	localparam int BIT_IDLE = 2;
	localparam int BIT_SLEEP = 3;
	localparam int BIT_WDT_FLAG = 4;
	localparam int BIT_SWDTEN = 5;
	localparam int BIT_SWR = 6;
	localparam int BIT_EXTR = 7;
	localparam int BIT_CF = 3;
	localparam int BIT_CODEC_DISABLE = 8;
	localparam logic [15:0] MODULE_DISABLE_RESET = 16'h0000;
	localparam logic [15:0] STATUS_POR_RESET = 16'h0003;
	localparam logic [15:0] CFG_DATA_MASK = 16'hffff;
	localparam logic [7:0] CFG_UPPER_READ = 8'h00;
	localparam logic [15:0] INVALID_READ = 16'h0000;

	// ****************************************
	// Timing
	// ****************************************
	localparam int INSTR_CYCLE_NS = 100;
	localparam int CLK_PERIOD_NS = 100;
	localparam int GATE_DELAY_CYCLES = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEBUG_RAM_BYTES = 80;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_IDLE = 4'b0010,
		ST_SLEEP = 4'b0100,
		ST_OSC_WAIT = 4'b1000
	} pswg_state_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [23:0] addr;
		logic [15:0] wdata;
	} pswg_bus_t;

	typedef struct packed {
		logic por;
		logic bor;
		logic extr;
		logic swr;
	} pswg_reset_src_t;

endpackage

// ==== rtl/pswg_top.sv ====
// Power-save wake control, wake status flags and peripheral clock gating
`timescale 1ns/1ps
module pswg_top #(
	parameter logic [15:0] PRESENT_ONE = 16'hfeff,
	parameter logic [15:0] PRESENT_TWO = 16'hffff,
	parameter logic [15:0] CFG_OSC = 16'hffff,
	parameter logic [15:0] CFG_WDT = 16'hffff,
	parameter logic [15:0] CFG_BOR_POR = 16'hffff,
	parameter logic [15:0] CFG_CODE_SEG = 16'hffff
)(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire pswg_pkg::pswg_bus_t bus,
	output logic [15:0] rdata,
	input wire logic table_rd,
	input wire logic [23:0] table_addr,
	output logic [23:0] table_data,
	input wire logic power_save_instruction,
	input wire logic power_save_sleep,
	input wire pswg_pkg::pswg_reset_src_t reset_src,
	input wire logic irq_pending,
	input wire logic interrupt_enable_bit,
	input wire logic irq_priority_ok,
	input wire logic wdt_timeout,
	input wire logic wdt_config_en,
	input wire logic osc_ready_pin,
	input wire logic fail_safe_clock_monitor,
	input wire logic debug_enable,
	input wire logic [15:0] periph_idle_stop_one,
	input wire logic [15:0] periph_idle_stop_two,
	output logic cpu_clk_en,
	output logic stall_exec,
	output logic vector_irq,
	output logic resume_next,
	output logic clock_fail_trap,
	output logic select_fast_rc,
	output logic osc_run,
	output logic low_power_rc_run,
	output logic [15:0] periph_clk_en_one,
	output logic [15:0] periph_clk_en_two,
	output logic [15:0] periph_bus_ok_one,
	output logic [15:0] periph_bus_ok_two,
	output logic debug_ram_reserved,
	output logic [1:0] debug_pins_reserved
);

	// ****************************************
	// State and registers
	// ****************************************
	pswg_pkg::pswg_state_t state_reg, state_next;
	logic [15:0] status_reg;
	logic [15:0] osc_ctl_reg;
	logic [15:0] mdis_one_reg, mdis_two_reg;
	logic [15:0] mdis_one_eff, mdis_two_eff;
	logic [2:0] osc_sync_reg;
	logic osc_stable;
	logic wake;
	logic irq_wake;
	logic any_reset;
	logic wr_status, wr_osc, wr_one, wr_two;
	logic in_idle, in_sleep, in_wait;

	// ****************************************
	// Oscillator ready synchroniser
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || in_sleep)
			osc_sync_reg <= 3'h0;
		else
			osc_sync_reg <= {osc_sync_reg[1:0], osc_ready_pin};
	end

	// Oscillator is off in Sleep, so stale ready must not end the wait
	logic osc_stable_reg;
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || in_sleep)
			osc_stable_reg <= 1'b0;
		else if (osc_sync_reg[1] == osc_sync_reg[2])
			osc_stable_reg <= osc_sync_reg[2];
	end
	assign osc_stable = osc_stable_reg;

	// ****************************************
	// Wake condition
	// ****************************************
	assign irq_wake = irq_pending && interrupt_enable_bit && irq_priority_ok;
	assign any_reset = reset_src.por | reset_src.bor | reset_src.extr | reset_src.swr;
	assign wake = irq_wake || any_reset || (wdt_timeout && wdt_config_en);
	assign in_idle = (state_reg == pswg_pkg::ST_IDLE);
	assign in_sleep = (state_reg == pswg_pkg::ST_SLEEP);
	assign in_wait = (state_reg == pswg_pkg::ST_OSC_WAIT);

	// ****************************************
	// Power state machine
	// ****************************************
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			pswg_pkg::ST_RUN:
			begin
				if (power_save_instruction)
					state_next = power_save_sleep ? pswg_pkg::ST_SLEEP : pswg_pkg::ST_IDLE;
			end
			pswg_pkg::ST_IDLE:
			begin
				if (wake)
					state_next = pswg_pkg::ST_RUN;
			end
			pswg_pkg::ST_SLEEP:
			begin
				if (wake)
					state_next = pswg_pkg::ST_OSC_WAIT;
			end
			pswg_pkg::ST_OSC_WAIT:
			begin
				if (osc_stable || fail_safe_clock_monitor)
					state_next = pswg_pkg::ST_RUN;
			end
			default: state_next = pswg_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			state_reg <= pswg_pkg::ST_RUN;
		else
			state_reg <= state_next;
	end

	// ****************************************
	// Processor side outputs
	// ****************************************
	logic irq_at_wake_reg;
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			irq_at_wake_reg <= 1'b0;
		else if ((in_idle || in_sleep) && wake)
			irq_at_wake_reg <= irq_wake && !any_reset;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			vector_irq <= 1'b0;
			resume_next <= 1'b0;
			clock_fail_trap <= 1'b0;
		end
		else
		begin
			vector_irq <= 1'b0;
			resume_next <= 1'b0;
			clock_fail_trap <= 1'b0;
			if (in_idle && wake && !any_reset)
			begin
				vector_irq <= irq_wake;
				resume_next <= !irq_wake;
			end
			if (in_wait && (osc_stable || fail_safe_clock_monitor))
			begin
				clock_fail_trap <= !osc_stable;
				vector_irq <= osc_stable && irq_at_wake_reg;
				resume_next <= osc_stable && !irq_at_wake_reg;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			select_fast_rc <= 1'b0;
		else if (in_wait && !osc_stable && fail_safe_clock_monitor)
			select_fast_rc <= 1'b1;
		else if (wr_osc && !bus.wdata[pswg_pkg::BIT_CF])
			select_fast_rc <= 1'b0;
	end

	assign cpu_clk_en = (state_reg == pswg_pkg::ST_RUN);
	assign stall_exec = in_wait;
	assign osc_run = !in_sleep;
	assign low_power_rc_run = (in_sleep && wdt_config_en)
		|| (in_idle && fail_safe_clock_monitor) || (!in_sleep && !in_idle);

	// ****************************************
	// Register bus decode
	// ****************************************
	assign wr_status = bus.req && bus.we && bus.addr == pswg_pkg::ADDR_RESET_POWER_STATUS;
	assign wr_osc = bus.req && bus.we && bus.addr == pswg_pkg::ADDR_OSC_CONTROL;
	assign wr_one = bus.req && bus.we && bus.addr == pswg_pkg::ADDR_MODULE_DISABLE_ONE;
	assign wr_two = bus.req && bus.we && bus.addr == pswg_pkg::ADDR_MODULE_DISABLE_TWO;

	// ****************************************
	// Wake and reset status flags
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			status_reg <= pswg_pkg::STATUS_POR_RESET;
		else if (reset_src.por)
			status_reg <= pswg_pkg::STATUS_POR_RESET;
		else
		begin
			if (wr_status)
				status_reg <= bus.wdata;
			if (reset_src.bor)
				status_reg[pswg_pkg::BIT_BOR] <= 1'b1;
			if (reset_src.extr)
				status_reg[pswg_pkg::BIT_EXTR] <= 1'b1;
			if (reset_src.swr)
				status_reg[pswg_pkg::BIT_SWR] <= 1'b1;
			if (in_sleep && wake)
				status_reg[pswg_pkg::BIT_SLEEP] <= 1'b1;
			if (in_idle && wake)
				status_reg[pswg_pkg::BIT_IDLE] <= 1'b1;
			if ((in_sleep || in_idle) && wdt_timeout && wdt_config_en)
				status_reg[pswg_pkg::BIT_WDT_FLAG] <= 1'b1;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			osc_ctl_reg <= 16'h0000;
		else if (wr_osc)
			osc_ctl_reg <= bus.wdata;
	end

	// ****************************************
	// Module disable registers
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			mdis_one_reg <= pswg_pkg::MODULE_DISABLE_RESET;
			mdis_two_reg <= pswg_pkg::MODULE_DISABLE_RESET;
		end
		else
		begin
			if (wr_one)
				mdis_one_reg <= bus.wdata;
			if (wr_two)
				mdis_two_reg <= bus.wdata;
		end
	end

	pswg_gate_delay #(
		.WIDTH(32),
		.DEPTH(pswg_pkg::GATE_DELAY_CYCLES)
	) u_gate_delay (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.din({mdis_two_reg, mdis_one_reg}),
		.dout({mdis_two_eff, mdis_one_eff})
	);

	// ****************************************
	// Peripheral clock gating
	// ****************************************
	always_comb
	begin
		periph_bus_ok_one = ~mdis_one_eff & PRESENT_ONE;
		periph_bus_ok_two = ~mdis_two_eff & PRESENT_TWO;
		periph_clk_en_one = periph_bus_ok_one;
		periph_clk_en_two = periph_bus_ok_two;
		if (in_sleep || in_wait)
		begin
			periph_clk_en_one = 16'h0000;
			periph_clk_en_two = 16'h0000;
		end
		else if (in_idle)
		begin
			periph_clk_en_one = periph_bus_ok_one & ~periph_idle_stop_one;
			periph_clk_en_two = periph_bus_ok_two & ~periph_idle_stop_two;
		end
	end

	// ****************************************
	// Read path and configuration words
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			rdata <= 16'h0000;
		else if (bus.req && !bus.we)
		begin
			unique case (bus.addr)
				pswg_pkg::ADDR_RESET_POWER_STATUS: rdata <= status_reg;
				pswg_pkg::ADDR_OSC_CONTROL:
					rdata <= osc_ctl_reg | {12'h000, select_fast_rc, 3'h0};
				pswg_pkg::ADDR_MODULE_DISABLE_ONE: rdata <= mdis_one_reg;
				pswg_pkg::ADDR_MODULE_DISABLE_TWO: rdata <= mdis_two_reg;
				default: rdata <= pswg_pkg::INVALID_READ;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			table_data <= 24'h000000;
		else if (table_rd)
		begin
			unique case (table_addr)
				pswg_pkg::ADDR_OSC_CONFIG:
					table_data <= {pswg_pkg::CFG_UPPER_READ, CFG_OSC & pswg_pkg::CFG_DATA_MASK};
				pswg_pkg::ADDR_WDT_CONFIG:
					table_data <= {pswg_pkg::CFG_UPPER_READ, CFG_WDT};
				pswg_pkg::ADDR_BOR_POR_CONFIG:
					table_data <= {pswg_pkg::CFG_UPPER_READ, CFG_BOR_POR};
				pswg_pkg::ADDR_CODE_SEG_CONFIG:
					table_data <= {pswg_pkg::CFG_UPPER_READ, CFG_CODE_SEG};
				default: table_data <= 24'h000000;
			endcase
		end
	end

	assign debug_ram_reserved = debug_enable;
	assign debug_pins_reserved = {debug_enable, debug_enable};

	// ****************************************
	// Checks
	// ****************************************
	chk_sleep_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_sleep && wake && !reset_src.por |=> status_reg[pswg_pkg::BIT_SLEEP])
		else $error("sleep flag not set on wake");
	chk_idle_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_idle && wake && !reset_src.por |=> status_reg[pswg_pkg::BIT_IDLE])
		else $error("idle flag not set on wake");
	chk_por_clears_flags: assert property (@(posedge core_clk) disable iff (!rst_n)
		reset_src.por |=> !status_reg[pswg_pkg::BIT_SLEEP] && !status_reg[pswg_pkg::BIT_IDLE])
		else $error("power-on did not clear flags");
	chk_wdt_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
		(in_sleep || in_idle) && wdt_timeout && wdt_config_en && !reset_src.por
		|=> status_reg[pswg_pkg::BIT_WDT_FLAG])
		else $error("watchdog flag not set");
	chk_idle_fast_exit: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_idle && wake |=> cpu_clk_en)
		else $error("idle exit delayed");
	chk_idle_cpu_only: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_idle |-> !cpu_clk_en && osc_run)
		else $error("idle gating wrong");
	chk_osc_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_wait && !osc_stable && !fail_safe_clock_monitor |=> in_wait && stall_exec)
		else $error("left wait without clock");
	chk_fail_trap: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_wait && !osc_stable && fail_safe_clock_monitor |=> clock_fail_trap && select_fast_rc)
		else $error("clock failure trap missing");
	chk_gate_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
		wr_one ##1 !wr_one |=> mdis_one_eff == $past(mdis_one_reg))
		else $error("disable bit delay wrong");
	chk_sleep_clocks: assert property (@(posedge core_clk) disable iff (!rst_n)
		in_sleep |-> periph_clk_en_one == 16'h0000 && !osc_run && !cpu_clk_en)
		else $error("sleep clocks running");

endmodule

// ==== testbench/pswg_osc_model.sv ====
// Behavioural model of the main oscillator seen by the wake logic
`timescale 1ns/1ps
module pswg_osc_model #(
	parameter int START_CYCLES = 6
)(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic osc_run,
	input wire logic dead,
	output logic osc_ready
);
	int cnt;

	// ****************************************
	// Start-up after each restart
	// ****************************************
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cnt <= 0;
			osc_ready <= 1'h1;
		end
		else if (!osc_run || dead)
		begin
			cnt <= 0;
			osc_ready <= 1'h0;
		end
		else if (cnt < START_CYCLES)
			cnt <= cnt + 1;
		else
			osc_ready <= 1'h1;
	end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the power-save wake and module gating block
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] P1 = 16'hfeff;
	localparam logic [15:0] P2 = 16'hffff;
	localparam logic [23:0] ST = 24'h000740;
	localparam logic [23:0] M1 = 24'h000770;
	logic core_clk, rst_n, table_rd, psi, pss, irq, ie, prio, wdt, wdt_en, osc_ok;
	logic fsm, dbg, cpu_en, stall, vec, res, trap, fast_internal_rc_oscillator, osc_run, low_power_rc_oscillator, dead;
	logic [15:0] rdata, is1, is2, ce1, ce2, ok1, ok2, d;
	logic [23:0] table_addr, table_data;
	logic [1:0] dpins;
	pswg_pkg::pswg_bus_t bus;
	pswg_pkg::pswg_reset_src_t rsrc;
	int err_total, cmp_count, seed, m1, m2, old, k, i;
	int cfgq[$] = '{32'h1234, 32'h8765, 32'h0f0f, 32'h0003};
	int cfga[$] = '{32'hf80000, 32'hf80002, 32'hf80004, 32'hf8000a};
	int flg[4] = '{32'h04, 32'h14, 32'h84, 32'h00};
	logic s_st, s_v, s_t;
	logic dram;

	pswg_top #(.PRESENT_ONE(P1), .PRESENT_TWO(P2), .CFG_OSC(16'h1234), .CFG_WDT(16'h8765),
		.CFG_BOR_POR(16'h0f0f), .CFG_CODE_SEG(16'h0003)) uut (.core_clk(core_clk),
		.rst_n(rst_n), .bus(bus), .rdata(rdata), .table_rd(table_rd),
		.table_addr(table_addr), .table_data(table_data), .power_save_instruction(psi),
		.power_save_sleep(pss), .reset_src(rsrc), .irq_pending(irq),
		.interrupt_enable_bit(ie), .irq_priority_ok(prio), .wdt_timeout(wdt),
		.wdt_config_en(wdt_en), .osc_ready_pin(osc_ok), .fail_safe_clock_monitor(fsm),
		.debug_enable(dbg), .periph_idle_stop_one(is1), .periph_idle_stop_two(is2),
		.cpu_clk_en(cpu_en), .stall_exec(stall), .vector_irq(vec), .resume_next(res),
		.clock_fail_trap(trap), .select_fast_rc(fast_internal_rc_oscillator), .osc_run(osc_run),
		.low_power_rc_run(low_power_rc_oscillator), .periph_clk_en_one(ce1), .periph_clk_en_two(ce2),
		.periph_bus_ok_one(ok1), .periph_bus_ok_two(ok2), .debug_ram_reserved(dram),
		.debug_pins_reserved(dpins));
	pswg_osc_model #(.START_CYCLES(6)) osc (.core_clk(core_clk), .rst_n(rst_n),
		.osc_run(osc_run), .dead(dead), .osc_ready(osc_ok));

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial
	begin
		core_clk = 1'h0;
		forever #50 core_clk = ~core_clk;
	end
	initial
	begin
		#2000000;
		err_total++;
		summarize();
	end

	// ****************************************
	// Tasks
	// ****************************************
	task chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [23:0] a, input logic [15:0] v);
		@(posedge core_clk);
		bus <= '{1'h1, 1'h1, a, v};
		@(posedge core_clk);
		bus.req <= 1'h0;
	endtask
	task rd(input logic [23:0] a, output logic [15:0] v);
		@(posedge core_clk);
		bus <= '{1'h1, 1'h0, a, 16'h0000};
		@(posedge core_clk);
		bus.req <= 1'h0;
		#1 v = rdata;
	endtask
	task enter(input logic s);
		@(posedge core_clk);
		psi <= 1'h1;
		pss <= s;
		@(posedge core_clk);
		psi <= 1'h0;
		repeat (2) @(posedge core_clk);
		#1;
	endtask
	task pulse_wake(input int w);
		@(posedge core_clk);
		case (w)
			0: {irq, ie, prio} <= 3'h7;
			1: wdt <= 1'h1;
			2: rsrc.extr <= 1'h1;
			default: rsrc.por <= 1'h1;
		endcase
		@(posedge core_clk);
		{irq, ie, prio, wdt} <= 4'h0;
		rsrc <= '0;
	endtask
	task waitrun();
		{s_st, s_v, s_t} = 3'h0;
		for (i = 0; i < 40 && cpu_en !== 1'h1; i++)
		begin
			@(posedge core_clk);
			#1;
			s_st |= stall;
			s_v |= vec;
			s_t |= trap;
		end
	endtask
	task summarize();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		seed = 32'h268a;
		{rst_n, table_rd, psi, pss, irq, ie, prio, wdt, dead} = 9'h0;
		{wdt_en, fsm, dbg} = 3'h7;
		bus = '0;
		rsrc = '0;
		table_addr = 24'h000000;
		is1 = $random(seed);
		is2 = $random(seed);
		repeat (16) @(posedge core_clk);
		rst_n <= 1'h1;
		rd(ST, d); chk(d, 16'h0003);
		rd(M1, d); chk(d, 16'h0000);
		rd(24'h000774, d); chk(d, 16'h0000);
		chk(ce1, P1);
		chk(ce2, P2);
		chk(dram, 1'h1);
		chk(dpins, 2'h3);
		dbg <= 1'h0;
		#1 chk(dram, 1'h0);
		chk(dpins, 2'h0);
		$display("Reset test done");
		old = 0;
		for (k = 0; k < 4; k++)
		begin
			m1 = $random(seed) | ((k == 0) ? 32'h100 : 32'h0);
			m2 = $random(seed);
			wr(M1, m1[15:0]);
			#1 chk(ce1, P1 & ~old[15:0]);
			@(posedge core_clk);
			#1 chk(ce1, P1 & ~m1[15:0]);
			chk(ok1, P1 & ~m1[15:0]);
			wr(M1 + 24'h2, m2[15:0]);
			repeat (2) @(posedge core_clk);
			#1 chk(ce2, P2 & ~m2[15:0]);
			chk(ok2, P2 & ~m2[15:0]);
			rd(M1, d); chk(d, m1[15:0]);
			old = m1;
		end
		for (k = 0; k < 4; k++)
		begin
			@(posedge core_clk);
			table_rd <= 1'h1;
			table_addr <= cfga[k][23:0];
			@(posedge core_clk);
			table_rd <= 1'h0;
			#1 chk(table_data, {8'h00, cfgq[k][15:0]});
		end
		$display("Gating and table test done");
		for (k = 0; k < 4; k++)
		begin
			wr(ST, 16'h0000);
			enter(1'h0);
			chk(cpu_en, 1'h0);
			chk(osc_run, 1'h1);
			chk(low_power_rc_oscillator, 1'h1);
			chk(ce1, P1 & ~m1[15:0] & ~is1);
			@(posedge core_clk);
			{irq, ie} <= 2'h3;
			repeat (3) @(posedge core_clk);
			#1 chk(cpu_en, 1'h0);
			pulse_wake(k);
			#1 chk(cpu_en, 1'h1);
			chk(vec, k == 0);
			if (k < 2) chk(res, k == 1);
			rd(ST, d); chk(d & 16'h009c, flg[k]);
		end
		$display("Idle test done");
		wr(ST, 16'h0000);
		fsm <= 1'h0;
		enter(1'h1);
		chk(osc_run, 1'h0);
		chk(ce1, 16'h0000);
		chk(low_power_rc_oscillator, 1'h1);
		pulse_wake(0);
		waitrun();
		chk({s_st, s_v, cpu_en}, 3'h7);
		rd(ST, d); chk(d & 16'h009c, 16'h0008);
		wr(ST, 16'h0000);
		fsm <= 1'h1;
		dead <= 1'h1;
		enter(1'h1);
		pulse_wake(1);
		waitrun();
		chk({s_t, fast_internal_rc_oscillator}, 2'h3);
		rd(ST, d); chk(d & 16'h009c, 16'h0018);
		dead <= 1'h0;
		wr(24'h000742, 16'h0000);
		@(posedge core_clk);
		#1 chk(fast_internal_rc_oscillator, 1'h0);
		$display("Sleep test done");
		summarize();
	end
endmodule
